/* File: bench/interrupt_source_mapping_tb.sv */
// self-checking bench for the interrupt source mapping block
// assumes level sources on mclk and an axi4-lite slave that answers in a few cycles
module interrupt_source_mapping_tb import ism_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [32:0] src = '0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cpu_req_q, irq_q;
  logic [1:0] bresp, rresp, cpu_level_q, rs;
  logic [4:0] cpu_line_q;
  logic [15:0] cpu_vec_hi_q, cpu_vec_lo_q;
  logic [31:0] rdata, fetch_q, rd;
  logic [31:0] rng = 32'd66140;
  logic [47:0] lv;
  logic [7:0] wexp;
  logic [31:0] wword;
  int mismatches = 0;
  int samples_checked = 0;
  // request line of each bench source bit
  int map[33] = '{0, 1, 2, 3, 0, 1, 2, 3, 4, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 16, 16,
                  17, 17, 18, 19, 19, 20, 21, 22, 23};

  ism_top i_dut (.mclk(mclk), .reset(reset), .ext_int(src[7:0]), .uart_sync_serial_port0(src[8]),
    .dead_time_trip_input(src[9]), .ctim0_lo(src[10]), .ctim0_hi(src[11]), .lin_rx(src[12]), .lin_tx(src[13]),
    .pulse_generator1_lo(src[14]), .pulse_generator1_hi(src[15]), .pulse_generator2_hi(src[16]),
    .pulse_generator0_hi(src[17]), .pulse_generator0_lo(src[18]), .ctim1_hi(src[19]),
    .pulse_generator2_lo(src[20]), .reload_tim1(src[21]), .waveform_sequencer_wt(src[22]), .i2c0(src[23]),
    .pulse_tim1(src[24]), .waveform_sequencer_pos(src[25]), .adc(src[26]), .time_base(src[27]),
    .watch_prescaler(src[28]), .cmp0(src[29]), .cmp1(src[30]), .ctim1_lo(src[31]), .flash(src[32]),
    .cpu_req_q(cpu_req_q), .cpu_line_q(cpu_line_q), .cpu_level_q(cpu_level_q), .cpu_vec_hi_q(cpu_vec_hi_q),
    .cpu_vec_lo_q(cpu_vec_lo_q), .irq_q(irq_q), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  ism_cpu_model i_cpu (.mclk(mclk), .reset(reset), .req(cpu_req_q), .vec_hi(cpu_vec_hi_q),
    .vec_lo(cpu_vec_lo_q), .fetch_q(fetch_q));

  initial begin
    forever #4 mclk = ~mclk;
  end

  function logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd

  function logic [23:0] lines_of(logic [32:0] s);
    lines_of = '0;
    for (int i = 0; i < 33; i++) if (s[i]) lines_of[map[i]] = 1'b1;
  endfunction : lines_of

  // {req, line, level}; scanning downwards leaves the lowest level, then lowest line
  function logic [7:0] win(logic [23:0] l, logic [47:0] v);
    win = 8'h00;
    for (int k = 3; k >= 0; k--)
      for (int n = 23; n >= 0; n--)
        if (l[n] && v[2*n +: 2] == k[1:0]) win = {1'b1, n[4:0], k[1:0]};
  endfunction : win

  task summarize();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task check_val(string name, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val

  task check_win(logic [23:0] l);
    logic [7:0] w;
    logic [15:0] v;
    w = win(l, lv);
    v = VEC_TOP - {10'h000, w[6:2], 1'b0};
    check_val("request", {31'h0, w[7]}, {31'h0, cpu_req_q});
    if (w[7]) begin
      check_val("winner", {24'h0, w}, {24'h0, cpu_req_q, cpu_line_q, cpu_level_q});
      check_val("vectors", {v, v + 16'h1}, {cpu_vec_hi_q, cpu_vec_lo_q});
      check_val("fetched", {v, v + 16'h1}, fetch_q);
    end
  endtask : check_win

  // source change lands on the winner two edges later, on irq one edge after that
  task settle(logic [32:0] s);
    @(posedge mclk);
    src <= s;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle

  task axi_wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    lv = '1;
    for (int k = 0; k < 6; k++) begin
      axi_rd(OFS_LVL0 + 8'(4 * k), rd, rs);
      check_val("level reset", {24'h0, LVL_RST}, rd);
    end
    axi_rd(OFS_MASK, rd, rs);
    check_val("mask reset", {8'h0, MASK_RST}, rd);
    axi_rd(8'h40, rd, rs);
    check_val("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rs});
    axi_wr(8'h40, 32'hFF, rs);
    check_val("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rs});
    // every source alone, shared lines included
    for (int i = 0; i < 33; i++) begin
      settle(33'h1 << i);
      check_win(lines_of(33'h1 << i));
    end
    // first pass: every line pending at one level, then random levels and sparse sources
    for (int t = 0; t < 24; t++) begin
      rd = rnd();
      lv = (t == 0) ? '0 : {rd[15:0], rnd()};
      for (int k = 0; k < 6; k++) axi_wr(OFS_LVL0 + 8'(4 * k), {24'h0, lv[8*k +: 8]}, rs);
      rd = rnd();
      settle((t == 0) ? '1 : {rd[0], rnd() & rnd() & rd});
      check_win(lines_of(src));
      // winner word over the bus, sources still held
      wexp = win(lines_of(src), lv);
      wword = {VEC_TOP - {10'h000, wexp[6:2], 1'b0}, 7'h00, wexp[7], 1'b0, wexp[1:0], wexp[6:2]};
      axi_rd(OFS_WIN, rd, rs);
      if (wexp[7]) check_val("winner word", wword, rd);
    end
    axi_rd(OFS_LVL0 + 8'h14, rd, rs);
    check_val("level readback", {24'h0, lv[47:40]}, rd);
    // sticky status, mask onto irq, write one to clear
    settle('0);
    axi_wr(OFS_STAT, 32'hFFFFFF, rs);
    // only lane 1 enabled: the other lanes keep their old zeros
    wstrb <= 4'h2;
    axi_wr(OFS_MASK, 32'hFFFF08FF, rs);
    wstrb <= 4'hF;
    check_val("mask write resp", {30'h0, RESP_OKAY}, {30'h0, rs});
    axi_rd(OFS_MASK, rd, rs);
    check_val("mask strobed", 32'h000800, rd);
    settle(33'h1 << 18);
    check_val("irq masked", 32'h0, {31'h0, irq_q});
    settle(33'h1 << 16);
    check_val("irq raised", 32'h1, {31'h0, irq_q});
    settle('0);
    axi_rd(OFS_STAT, rd, rs);
    check_val("status sticky", 32'h002800, rd);
    axi_wr(OFS_STAT, 32'h000800, rs);
    axi_rd(OFS_STAT, rd, rs);
    check_val("status cleared", 32'h002000, rd);
    repeat (3) @(posedge mclk);
    #1;
    check_val("irq dropped", 32'h0, {31'h0, irq_q});
    summarize();
  end

  // whole run is under a thousand cycles; this bounds a hung handshake
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    summarize();
  end
endmodule : interrupt_source_mapping_tb

/* File: bench/ism_cpu_model.sv */
// cpu-side model: takes the winning vector pair as the core would fetch it
// assumes the winner outputs are registered on mclk; the core never refuses
module ism_cpu_model (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // winner from the block
  input wire logic req,
  input wire logic [15:0] vec_hi,
  input wire logic [15:0] vec_lo,
  // fetched upper and lower vector address, held while nothing is pending
  output logic [31:0] fetch_q
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) fetch_q <= 32'h0;
    else if (req) fetch_q <= {vec_hi, vec_lo};
  end
endmodule : ism_cpu_model

/* File: rtl/ism_pkg.sv */
// constants and helpers for the interrupt source mapping block
// assumes one clock domain and a 32-bit axi4-lite register bus
package ism_pkg;
  localparam int NLINES = 24;
  localparam int NLVLREG = 6;
  // byte offsets of the register map
  localparam logic [7:0] OFS_LVL0 = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1C;
  localparam logic [7:0] OFS_WIN = 8'h20;
  // values after reset
  localparam logic [7:0] LVL_RST = 8'hFF;
  localparam logic [23:0] MASK_RST = 24'h000000;
  // vector of line 0, two bytes per line going down
  localparam logic [15:0] VEC_TOP = 16'hFFFA;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // upper-byte vector address of a line
  function automatic logic [15:0] vec_upper(input logic [4:0] n);
    vec_upper = VEC_TOP - {10'h000, n, 1'b0};
  endfunction : vec_upper

  // two-bit level field of a line, four fields per level register
  function automatic logic [1:0] lvl_of(input logic [47:0] lv, input logic [4:0] n);
    lvl_of = lv[{n, 1'b0} +: 2];
  endfunction : lvl_of

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge
endpackage : ism_pkg

/* File: rtl/ism_top.sv */
// interrupt source mapping: 24 request lines, levels, vectors, fixed order
// assumes every source is a level from logic on mclk; cpu takes the winner
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
module ism_top
  import ism_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // interrupt sources
  input wire logic [7:0] ext_int,
  input wire logic uart_sync_serial_port0,
  input wire logic dead_time_trip_input,
  input wire logic ctim0_lo,
  input wire logic ctim0_hi,
  input wire logic lin_rx,
  input wire logic lin_tx,
  input wire logic pulse_generator1_lo,
  input wire logic pulse_generator1_hi,
  input wire logic pulse_generator2_hi,
  input wire logic pulse_generator0_hi,
  input wire logic pulse_generator0_lo,
  input wire logic ctim1_hi,
  input wire logic pulse_generator2_lo,
  input wire logic reload_tim1,
  input wire logic waveform_sequencer_wt,
  input wire logic i2c0,
  input wire logic pulse_tim1,
  input wire logic waveform_sequencer_pos,
  input wire logic adc,
  input wire logic time_base,
  input wire logic watch_prescaler,
  input wire logic cmp0,
  input wire logic cmp1,
  input wire logic ctim1_lo,
  input wire logic flash,
  // request to the cpu
  output logic cpu_req_q,
  output logic [4:0] cpu_line_q,
  output logic [1:0] cpu_level_q,
  output logic [15:0] cpu_vec_hi_q,
  output logic [15:0] cpu_vec_lo_q,
  output logic irq_q,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  logic [23:0] line_d, line_q;
  logic [47:0] lvl_q;
  logic [23:0] stat_q, mask_q;
  logic aw_got_q, w_got_q;
  logic [7:0] wa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;

  // line assembly; sources share mclk so no synchroniser
  assign line_d[3:0] = ext_int[3:0] | ext_int[7:4];
  assign line_d[4] = uart_sync_serial_port0 | dead_time_trip_input;
  assign line_d[5] = ctim0_lo;
  assign line_d[6] = ctim0_hi;
  assign line_d[7] = lin_rx;
  assign line_d[8] = lin_tx;
  assign line_d[9] = pulse_generator1_lo;
  assign line_d[10] = pulse_generator1_hi;
  assign line_d[11] = pulse_generator2_hi;
  assign line_d[12] = pulse_generator0_hi;
  assign line_d[13] = pulse_generator0_lo;
  assign line_d[14] = ctim1_hi;
  assign line_d[15] = pulse_generator2_lo;
  assign line_d[16] = reload_tim1 | waveform_sequencer_wt | i2c0;
  assign line_d[17] = pulse_tim1 | waveform_sequencer_pos;
  assign line_d[18] = adc;
  assign line_d[19] = time_base | watch_prescaler;
  assign line_d[20] = cmp0;
  assign line_d[21] = cmp1;
  assign line_d[22] = ctim1_lo;
  assign line_d[23] = flash;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      line_q <= 24'h000000;
    end else begin
      line_q <= line_d;
    end
  end

  // arbitration: lowest level value first, then lowest line
  logic win_found;
  logic [4:0] win_idx;
  logic [1:0] win_lvl;
  always_comb begin
    win_found = 1'b0;
    win_idx = 5'h00;
    win_lvl = 2'h3;
    // walk downward so an equal level at a lower line overrides
    for (int i = NLINES - 1; i >= 0; i--) begin
      if (line_q[i] && (!win_found || lvl_of(lvl_q, 5'(i)) <= win_lvl)) begin
        win_found = 1'b1;
        win_idx = 5'(i);
        win_lvl = lvl_of(lvl_q, 5'(i));
      end
    end
  end

  wire [15:0] win_vec = vec_upper(win_idx);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cpu_req_q <= 1'b0;
      cpu_line_q <= 5'h00;
      cpu_level_q <= 2'h0;
      cpu_vec_hi_q <= VEC_TOP;
      cpu_vec_lo_q <= VEC_TOP + 16'h0001;
    end else begin
      cpu_req_q <= win_found;
      cpu_line_q <= win_idx;
      cpu_level_q <= win_lvl;
      cpu_vec_hi_q <= win_vec;
      cpu_vec_lo_q <= win_vec + 16'h0001;
    end
  end

  // axi write path: address and data taken in either order
  wire aw_hs = awvalid & awready;
  wire w_hs = wvalid & wready;
  wire do_wr = aw_got_q & w_got_q & ~bvalid;
  wire [2:0] wr_idx = wa_q[4:2];
  wire wr_lvl = do_wr && wa_q < OFS_STAT && wa_q[1:0] == 2'h0;
  wire wr_stat = do_wr && wa_q == OFS_STAT;
  wire wr_mask = do_wr && wa_q == OFS_MASK;
  wire wr_ok = wr_lvl | wr_stat | wr_mask;
  wire [31:0] stat_wv = merge(32'h0, wd_q, ws_q);
  wire [23:0] w1c = wr_stat ? stat_wv[23:0] : 24'h000000;
  wire [31:0] mask_wv = merge({8'h00, mask_q}, wd_q, ws_q);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      wa_q <= 8'h00;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awready <= 1'b0;
        aw_got_q <= 1'b1;
        wa_q <= awaddr;
      end
      if (w_hs) begin
        wready <= 1'b0;
        w_got_q <= 1'b1;
        wd_q <= wdata;
        ws_q <= wstrb;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // level registers, one byte each in the low lane
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lvl_q <= {NLVLREG{LVL_RST}};
    end else if (wr_lvl && ws_q[0]) begin
      lvl_q[{wr_idx, 3'h0} +: 8] <= wd_q[7:0];
    end
  end

  // sticky status: a line held high re-sets its bit, so set beats clear
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stat_q <= 24'h000000;
      mask_q <= MASK_RST;
      irq_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~w1c) | line_q;
      if (wr_mask) begin
        mask_q <= mask_wv[23:0];
      end
      irq_q <= |(stat_q & mask_q);
    end
  end

  // axi read path, answer one cycle after the address is taken
  wire [7:0] ra = araddr;
  wire rd_lvl = ra < OFS_STAT && ra[1:0] == 2'h0;
  wire [7:0] rd_lvl_v = lvl_q[{ra[4:2], 3'h0} +: 8];
  wire rd_ok = rd_lvl || ra == OFS_STAT || ra == OFS_MASK || ra == OFS_WIN;
  wire [31:0] win_word = {cpu_vec_hi_q, 7'h00, cpu_req_q, 1'b0, cpu_level_q, cpu_line_q};
  wire [31:0] rd_v = rd_lvl ? {24'h000000, rd_lvl_v} :
                     ra == OFS_STAT ? {8'h00, stat_q} :
                     ra == OFS_MASK ? {8'h00, mask_q} :
                     ra == OFS_WIN ? win_word : 32'h0;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_v;
        rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // helper: a lower line pending at the winner's level would be a priority slip
  logic beaten;
  always_comb begin
    beaten = 1'b0;
    for (int j = 0; j < NLINES; j++) begin
      if (win_found && 5'(j) < win_idx && line_q[j] && lvl_of(lvl_q, 5'(j)) <= win_lvl) begin
        beaten = 1'b1;
      end
    end
  end

  lvl_write_a:
  assert property (@(posedge mclk) disable iff (reset)
    (wr_lvl && ws_q[0]) |=> lvl_q[{$past(wr_idx), 3'h0} +: 8] == $past(wd_q[7:0]))
    else $error("level register write not stored");

  vec_addr_a:
  assert property (@(posedge mclk) disable iff (reset)
    cpu_req_q |-> cpu_vec_hi_q == VEC_TOP - {10'h000, cpu_line_q, 1'b0}
      && cpu_vec_lo_q == cpu_vec_hi_q + 16'h0001)
    else $error("vector address does not match line");

  prio_order_a:
  assert property (@(posedge mclk) disable iff (reset) !beaten)
    else $error("higher priority pending line lost arbitration");

  win_track_a:
  assert property (@(posedge mclk) disable iff (reset)
    win_found |=> cpu_req_q && cpu_line_q == $past(win_idx) && $past(line_q[win_idx]))
    else $error("cpu request does not follow winner");

  ext_share_a:
  assert property (@(posedge mclk) disable iff (reset)
    ##1 line_q[3:0] == ($past(ext_int[3:0]) | $past(ext_int[7:4])))
    else $error("external channel pair not merged");

  line16_or_a:
  assert property (@(posedge mclk) disable iff (reset)
    (reload_tim1 || waveform_sequencer_wt || i2c0) |=> line_q[16])
    else $error("line 16 missed a source");

  line17_or_a:
  assert property (@(posedge mclk) disable iff (reset)
    (pulse_tim1 || waveform_sequencer_pos) |=> line_q[17])
    else $error("line 17 missed a source");

  ctim_map_a:
  assert property (@(posedge mclk) disable iff (reset)
    ##1 {line_q[5], line_q[6], line_q[14], line_q[22]}
      == $past({ctim0_lo, ctim0_hi, ctim1_hi, ctim1_lo}))
    else $error("composite timer lines misrouted");

  pgen_map_a:
  assert property (@(posedge mclk) disable iff (reset)
    ##1 {line_q[9], line_q[10], line_q[13], line_q[12]} == $past({pulse_generator1_lo,
      pulse_generator1_hi, pulse_generator0_lo, pulse_generator0_hi}))
    else $error("pulse generator 0 or 1 misrouted");

  pgen2_map_a:
  assert property (@(posedge mclk) disable iff (reset)
    ##1 {line_q[11], line_q[15]} == $past({pulse_generator2_hi, pulse_generator2_lo}))
    else $error("pulse generator 2 misrouted");

  shared_or_a:
  assert property (@(posedge mclk) disable iff (reset)
    ##1 (line_q[4] == $past(uart_sync_serial_port0 | dead_time_trip_input)
      && line_q[19] == $past(time_base | watch_prescaler)))
    else $error("shared line is not the or of its sources");

  // a line still high must win over a clear in the same cycle
  stat_set_a:
  assert property (@(posedge mclk) disable iff (reset)
    ##1 (stat_q & $past(line_q)) == $past(line_q))
    else $error("pending line did not set its status bit");

  irq_level_a:
  assert property (@(posedge mclk) disable iff (reset)
    ##1 irq_q == |($past(stat_q) & $past(mask_q)))
    else $error("interrupt output does not follow status and mask");

  wr_answer_a:
  assert property (@(posedge mclk) disable iff (reset)
    (aw_hs && w_hs) |-> ##2 bvalid)
    else $error("write response missing after address and data");

  rd_answer_a:
  assert property (@(posedge mclk) disable iff (reset)
    (arvalid && arready) |=> rvalid && !arready)
    else $error("read answer missing after the address");

endmodule : ism_top
